// [src/rename_cfg.svh]
/*
  Constants for the dependency tracking and rename block: field widths,
  operation codes, uop counts and port numbers.
  Assumes it is included by bare name wherever the numbers are needed.
*/
`ifndef RENAME_CFG_SVH
`define RENAME_CFG_SVH

// ============================================================
// Operation codes of decoded micro-operations
`define OP_XOR 5'h00
`define OP_SUB 5'h01
`define OP_PXOR 5'h02
`define OP_XORPS 5'h03
`define OP_XORPD 5'h04
`define OP_MOV_IMM 5'h05
`define OP_MOV 5'h06
`define OP_LEA 5'h07
`define OP_TEST 5'h08
`define OP_ADD 5'h09
`define OP_AND 5'h0a
`define OP_MOVSD_RR 5'h0b
`define OP_MOVAPD_RR 5'h0c
`define OP_MOVSD_LD 5'h0d
`define OP_MOVUPD_LD 5'h0e
`define OP_ADD_TO_MEM 5'h0f
`define OP_ADD_FROM_MEM 5'h10
`define OP_STORE 5'h11
`define OP_LOAD 5'h12

// ============================================================
// Segment selectors
`define SEG_DS 2'h0
`define SEG_SS 2'h1

// ============================================================
// Widths, ports and counts
`define SIMD_HALF 64
`define HALF_BYTES 32'h8
`define PORT_SCALAR 2'h0
`define PORT_PACKED 2'h1
`define PORT_ALU 2'h2
`define PORT_MEM 2'h3
`define LAT_SCALAR 4'h2
`define LAT_PACKED 4'h4
`define LAT_ALU 4'h1
`define LAT_MEM 4'h2
`define UOPS_ONE 3'h1
`define UOPS_MEMDST 3'h2
`define UOPS_MEMSRC_ST 3'h3
`define UOPS_UNALIGNED 3'h4
`define ADDR_ZERO 32'h0
`define SEG_SHIFT 4

`endif

// [src/rename_pkg.sv]
/*
  Types shared by the rename block and its address generator.
  Assumes rename_cfg.svh supplies the numeric constants.
*/
package rename_pkg;
  typedef logic [4:0] opcode_t;
  typedef logic [1:0] seg_t;
endpackage

// [src/agu_if.sv]
/*
  Carrier between the rename block and the address generator.
  Assumes both ends share the core clock.
*/
`timescale 1ns/1ps
interface agu_if #(parameter int AW = 32, parameter int RW = 4);
  logic [AW-1:0] reloc;
  logic [AW-1:0] imm;
  logic [AW-1:0] base;
  logic [AW-1:0] index;
  logic [1:0] scale;
  logic [RW-1:0] base_reg;
  logic [AW-1:0] seg_base_ds;
  logic [AW-1:0] seg_base_ss;
  logic flat;
  logic [AW-1:0] linear;
  rename_pkg::seg_t seg;
  modport req(output reloc, imm, base, index, scale, base_reg, seg_base_ds,
    seg_base_ss, flat, input linear, seg);
  modport gen(input reloc, imm, base, index, scale, base_reg, seg_base_ds,
    seg_base_ss, flat, output linear, seg);
endinterface

// [src/agu.sv]
/*
  Address generator: combines the memory reference operands and an
  optional segment base into a linear address.
  Assumes operands are stable while the request is being captured.
*/
`timescale 1ns/1ps
`include "rename_cfg.svh"
module agu #(
  parameter logic [3:0] FRAME_REG = 4'h5
) (
  agu_if.gen a
);
  // ============================================================
  // Offset sum and segment choice
  wire [31:0] offset;
  wire use_ss;
  assign offset = a.reloc + a.imm + a.base + (a.index << a.scale);
  // Frame-based references point into the stack segment unless the model is flat
  assign use_ss = !a.flat && (a.base_reg == FRAME_REG);
  assign a.seg = use_ss ? `SEG_SS : `SEG_DS;
  // Flat model ignores segment bases entirely
  assign a.linear = a.flat ? offset :
    offset + (use_ss ? a.seg_base_ss : a.seg_base_ds);
endmodule // agu

// [src/dependency_tracking_rename.sv]
/*
  Dependency tracking and rename stage for decoded micro-operations.
  Classifies each uop for dependency breaking, condition-code writes,
  SIMD partial writes, port choice and uop expansion, forms its address,
  and holds younger loads behind a store with an unknown address.
  Assumes one uop per cycle from the front end, synchronous inputs.
*/
// Summary of operation
// - Address from reloc, immediate, base, scaled index
// - Segment base added in segmented model
// - Same-register xor, sub, pxor break dependency
// - Floating xor with itself keeps dependency
// - Move zero clears, flags kept; xor/sub set
// - Bit test sets flags, writes no register
// - Arithmetic sets flags; move and lea don't
// - Scalar register move writes low half only
// - Packed move full write, other port, slower
// - Scalar load zero-fills, breaks dependency
// - Unaligned packed load: two halves plus merge
// - Add to memory: one uop fewer
// - Unknown store address holds younger loads
// - Frame base selects stack segment when segmented
`timescale 1ns/1ps
`include "rename_cfg.svh"
module dependency_tracking_rename #(
  parameter int AW = 32,
  parameter int RW = 4,
  parameter logic [3:0] FRAME_REG = 4'h5
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic in_valid,
  input wire rename_pkg::opcode_t in_op,
  input wire logic [RW-1:0] in_dst,
  input wire logic [RW-1:0] in_src1,
  input wire logic [RW-1:0] in_src2,
  input wire logic in_mem,
  input wire logic in_aligned,
  input wire logic [AW-1:0] in_reloc,
  input wire logic [AW-1:0] in_imm,
  input wire logic [AW-1:0] in_base,
  input wire logic [AW-1:0] in_index,
  input wire logic [1:0] in_scale,
  input wire logic [RW-1:0] in_base_reg,
  input wire logic [AW-1:0] seg_base_ds,
  input wire logic [AW-1:0] seg_base_ss,
  input wire logic flat_model,
  input wire logic store_addr_done,
  output logic in_ready,
  output logic out_valid,
  output rename_pkg::opcode_t out_op,
  output logic [RW-1:0] out_dst,
  output logic dep_break,
  output logic dep_on_src,
  output logic zero_result,
  output logic issue_now,
  output logic flags_write,
  output logic reg_write,
  output logic write_low_only,
  output logic dep_upper,
  output logic zero_fill_upper,
  output logic [1:0] exec_port,
  output logic [3:0] latency,
  output logic [2:0] uop_count,
  output logic split_load,
  output logic merge_halves,
  output logic [AW-1:0] lin_addr,
  output logic [AW-1:0] lin_addr_hi,
  output rename_pkg::seg_t seg_used,
  output logic store_pending
);
  // ============================================================
  // Address generation
  agu_if #(.AW(AW), .RW(RW)) ag();
  assign ag.reloc = in_reloc;
  assign ag.imm = in_imm;
  assign ag.base = in_base;
  assign ag.index = in_index;
  assign ag.scale = in_scale;
  assign ag.base_reg = in_base_reg;
  assign ag.seg_base_ds = seg_base_ds;
  assign ag.seg_base_ss = seg_base_ss;
  assign ag.flat = flat_model;
  agu #(.FRAME_REG(FRAME_REG)) u_agu (
    .a(ag)
  );

  // ============================================================
  // Decode
  wire same_src;
  wire is_clear_idiom;
  wire is_fp_xor;
  wire is_mov_zero;
  wire is_load;
  wire is_store;
  wire hold_load;
  wire take;
  wire no_flags;
  wire no_reg;
  wire is_simd_op;
  assign same_src = (in_src1 == in_src2);
  // Only integer and packed-integer forms get the special support
  assign is_clear_idiom = same_src && ((in_op == `OP_XOR) ||
    (in_op == `OP_SUB) || (in_op == `OP_PXOR));
  assign is_fp_xor = (in_op == `OP_XORPS) || (in_op == `OP_XORPD);
  assign is_mov_zero = (in_op == `OP_MOV_IMM) &&
    (in_imm == `ADDR_ZERO);
  assign is_store = (in_op == `OP_STORE) || (in_op == `OP_ADD_TO_MEM);
  assign is_load = in_mem && !is_store;
  // A load behind an unresolved store waits; no bypass is tried
  assign hold_load = is_load && store_pending &&
    !store_addr_done;
  assign take = in_valid && !hold_load;
  // Moves, lea and stores leave the flags alone
  assign no_flags = (in_op == `OP_MOV_IMM) || (in_op == `OP_MOV) ||
    (in_op == `OP_LEA) || (in_op == `OP_MOVSD_RR) ||
    (in_op == `OP_MOVAPD_RR) || (in_op == `OP_MOVSD_LD) ||
    (in_op == `OP_MOVUPD_LD) || (in_op == `OP_STORE) ||
    (in_op == `OP_LOAD) || is_fp_xor || (in_op == `OP_PXOR);
  assign no_reg = (in_op == `OP_TEST) || is_store;
  assign is_simd_op = (in_op == `OP_MOVSD_RR) ||
    (in_op == `OP_MOVAPD_RR) || (in_op == `OP_MOVSD_LD) ||
    (in_op == `OP_MOVUPD_LD);

  // ============================================================
  // Port, latency and uop count selection
  logic [1:0] next_port;
  logic [3:0] next_lat;
  logic [2:0] next_uops;
  always_comb begin
    next_port = `PORT_ALU;
    next_lat = `LAT_ALU;
    next_uops = `UOPS_ONE;
    if (in_op == `OP_MOVSD_RR) begin
      next_port = `PORT_SCALAR;
      next_lat = `LAT_SCALAR;
    end else if (in_op == `OP_MOVAPD_RR) begin
      next_port = `PORT_PACKED;
      next_lat = `LAT_PACKED;
    end else if (in_op == `OP_MOVUPD_LD && !in_aligned) begin
      next_port = `PORT_MEM;
      next_lat = `LAT_MEM;
      next_uops = `UOPS_UNALIGNED;
    end else if (in_op == `OP_ADD_TO_MEM) begin
      next_port = `PORT_MEM;
      next_lat = `LAT_MEM;
      next_uops = `UOPS_MEMDST;
    end else if (in_op == `OP_ADD_FROM_MEM) begin
      next_port = `PORT_MEM;
      next_lat = `LAT_MEM;
      next_uops = `UOPS_MEMSRC_ST;
    end else if (in_mem) begin
      next_port = `PORT_MEM;
      next_lat = `LAT_MEM;
    end
  end

  // ============================================================
  // Store-address tracker: set by a store, cleared on resolution
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      store_pending <= 1'b0;
    end else if (take && is_store) begin
      store_pending <= 1'b1;
    end else if (store_addr_done) begin
      store_pending <= 1'b0;
    end
  end

  // ============================================================
  // Output register stage
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      in_ready <= 1'b1;
      out_valid <= 1'b0;
      out_op <= `OP_XOR;
      out_dst <= '0;
      dep_break <= 1'b0;
      dep_on_src <= 1'b0;
      zero_result <= 1'b0;
      issue_now <= 1'b0;
      flags_write <= 1'b0;
      reg_write <= 1'b0;
      write_low_only <= 1'b0;
      dep_upper <= 1'b0;
      zero_fill_upper <= 1'b0;
      exec_port <= `PORT_ALU;
      latency <= `LAT_ALU;
      uop_count <= `UOPS_ONE;
      split_load <= 1'b0;
      merge_halves <= 1'b0;
      lin_addr <= '0;
      lin_addr_hi <= '0;
      seg_used <= `SEG_DS;
    end else begin
      // Only a presented load is refused; an idle cycle keeps ready high
      in_ready <= !(in_valid && hold_load);
      out_valid <= take;
      out_op <= in_op;
      out_dst <= in_dst;
      dep_break <= is_clear_idiom || is_mov_zero ||
        (in_op == `OP_MOVSD_LD) || (in_op == `OP_MOVAPD_RR);
      dep_on_src <= !is_clear_idiom && !is_mov_zero;
      zero_result <= is_clear_idiom || is_mov_zero;
      issue_now <= is_clear_idiom;
      flags_write <= !no_flags;
      reg_write <= !no_reg;
      write_low_only <= (in_op == `OP_MOVSD_RR);
      dep_upper <= (in_op == `OP_MOVSD_RR);
      zero_fill_upper <= (in_op == `OP_MOVSD_LD);
      exec_port <= is_simd_op || in_mem ? next_port : `PORT_ALU;
      latency <= next_lat;
      uop_count <= next_uops;
      split_load <= (in_op == `OP_MOVUPD_LD) && !in_aligned;
      merge_halves <= (in_op == `OP_MOVUPD_LD) && !in_aligned;
      lin_addr <= ag.linear;
      lin_addr_hi <= ag.linear + AW'(`HALF_BYTES);
      seg_used <= ag.seg;
    end
  end
endmodule // dependency_tracking_rename

// [tb/store_resolver.sv]
/* Far-side model: resolves a pending store address after a delay.
   Assumes store_pending is registered on the same core clock. */
`timescale 1ns/1ps
module store_resolver (
  input wire logic clk,
  input wire logic rstn,
  input wire logic store_pending,
  input wire logic [3:0] lag,
  output logic store_addr_done
);
  logic [3:0] cnt;
  // One-cycle pulse lag cycles after store_pending rises; a long lag models a slow address
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 4'h0;
      store_addr_done <= 1'b0;
    end else if (!store_pending || store_addr_done) begin
      cnt <= 4'h0;
      store_addr_done <= 1'b0;
    end else begin
      cnt <= cnt + 4'h1;
      store_addr_done <= (cnt + 4'h1 == lag);
    end
  end
endmodule // store_resolver

// [tb/rename_chk.sv]
/* Checker for the rename stage: answers one cycle after a uop.
   Assumes one core clock and rstn, bound onto the top module. */
`timescale 1ns/1ps
`include "rename_cfg.svh"
module rename_chk (
  input wire logic clk,
  input wire logic rstn,
  input wire logic in_valid,
  input wire rename_pkg::opcode_t in_op,
  input wire logic [3:0] in_src1,
  input wire logic [3:0] in_src2,
  input wire logic in_aligned,
  input wire logic in_mem,
  input wire logic [31:0] in_imm,
  input wire logic store_addr_done,
  input wire logic store_pending,
  input wire logic out_valid,
  input wire logic in_ready,
  input wire logic dep_break,
  input wire logic dep_on_src,
  input wire logic zero_result,
  input wire logic flags_write,
  input wire logic reg_write,
  input wire logic write_low_only,
  input wire logic dep_upper,
  input wire logic [1:0] exec_port,
  input wire logic [3:0] latency,
  input wire logic split_load,
  input wire logic merge_halves
);
  // ==========================================================
  // Classification one cycle after the uop
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_xor_idiom: assert property (
    in_valid && in_op == `OP_XOR && in_src1 == in_src2
    |=> out_valid && dep_break && zero_result) else $error("xor idiom");
  a_fp_xor_keeps: assert property (
    in_valid && (in_op == `OP_XORPS || in_op == `OP_XORPD)
    |=> !dep_break && dep_on_src) else $error("fp xor broke chain");
  a_mov_zero_flags: assert property (
    in_valid && in_op == `OP_MOV_IMM |=> !flags_write && reg_write)
    else $error("mov zero flags");
  a_mov_zero_clear: assert property (
    in_valid && in_op == `OP_MOV_IMM && in_imm == `ADDR_ZERO
    |=> zero_result && dep_break) else $error("mov zero not cleared");
  a_test_no_reg: assert property (
    in_valid && in_op == `OP_TEST |=> flags_write && !reg_write)
    else $error("test wrote register");
  a_lea_flags: assert property (
    in_valid && (in_op == `OP_LEA || in_op == `OP_MOV) |=> !flags_write)
    else $error("move set flags");
  a_scalar_low: assert property (
    in_valid && in_op == `OP_MOVSD_RR |=> write_low_only && dep_upper)
    else $error("scalar move full write");
  a_packed_port: assert property (
    in_valid && in_op == `OP_MOVAPD_RR |=> !write_low_only
    && exec_port == `PORT_PACKED && latency == `LAT_PACKED)
    else $error("packed move class");
  a_split_load: assert property (
    in_valid && in_op == `OP_MOVUPD_LD && !in_aligned && !store_pending
    |=> split_load && merge_halves) else $error("unaligned not split");
  a_load_held: assert property (
    in_valid && in_op == `OP_LOAD && in_mem && store_pending &&
    !store_addr_done
    |=> !out_valid && !in_ready) else $error("load passed store");
endmodule // rename_chk
bind dependency_tracking_rename rename_chk u_chk (.*);

// [tb/dependency_tracking_rename_tb.sv]
/* Self-checking bench for the rename stage with a store resolver.
   Assumes outputs settle within 1 ns of the taking edge. */
`timescale 1ns/1ps
`include "rename_cfg.svh"
module dependency_tracking_rename_tb;
  logic clk = 0, rstn = 0, in_valid = 0, in_mem = 0, in_aligned = 1;
  logic flat_model = 1, store_addr_done;
  rename_pkg::opcode_t in_op = 5'h0, out_op;
  logic [3:0] in_dst = 4'h1, in_src1 = 4'h0, in_src2 = 4'h0, lag = 4'h1;
  logic [3:0] in_base_reg = 4'h0, out_dst, latency;
  logic [31:0] in_reloc = 0, in_imm = 0, in_base = 0, in_index = 0;
  logic [31:0] seg_base_ds = 0, seg_base_ss = 0, lin_addr, lin_addr_hi, e;
  logic [1:0] in_scale = 2'h0, exec_port, seg_used;
  logic [2:0] uop_count, u;
  logic in_ready, out_valid, dep_break, dep_on_src, zero_result, issue_now;
  logic flags_write, reg_write, write_low_only, dep_upper, zero_fill_upper;
  logic split_load, merge_halves, store_pending;
  int n_mismatch = 0, cmp_count = 0, cyc = 0;
  dependency_tracking_rename dut (.*);
  store_resolver model (.*);
  // ==========================================================
  // Clock, watchdog and verdict
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      end_sim;
    end
  end
  task automatic end_sim;
    $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] x, logic [31:0] g);
    cmp_count++;
    if (g !== x) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", nm, x, g);
    end
  endtask
  // Waits out a pending store so a load is never refused here
  task automatic send(rename_pkg::opcode_t op, logic [3:0] s, logic m,
                      logic al);
    int n;
    n = 0;
    while (store_pending === 1'b1 && store_addr_done !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    in_op <= op;
    in_src1 <= s;
    in_src2 <= 4'h3;
    in_mem <= m;
    in_aligned <= al;
    in_valid <= 1'b1;
    @(posedge clk);
    in_valid <= 1'b0;
    #1;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_clear;
    rename_pkg::opcode_t o[5] = '{`OP_XOR, `OP_SUB, `OP_PXOR, `OP_XORPS,
                                  `OP_XORPD};
    foreach (o[i]) begin
      send(o[i], 4'h3, 1'b0, 1'b1);
      chk("dep_break", i < 3, dep_break);
      chk("fp_dep", i > 2, dep_on_src);
      chk("zero", i < 3, zero_result);
      chk("issue", i < 3, issue_now);
      chk("flags", i < 2, flags_write);
    end
    send(`OP_XOR, 4'h4, 1'b0, 1'b1);
    chk("other_src", 0, dep_break);
    $display("test clear done");
  endtask
  task automatic t_flags;
    rename_pkg::opcode_t o[5] = '{`OP_MOV_IMM, `OP_MOV, `OP_LEA, `OP_ADD,
                                  `OP_TEST};
    foreach (o[i]) begin
      send(o[i], 4'h2, 1'b0, 1'b1);
      chk("flags", i > 2, flags_write);
      chk("reg_write", i < 4, reg_write);
      chk("mov_zero", i == 0, zero_result);
    end
    @(posedge clk);
    in_imm <= 32'h7;
    send(`OP_MOV_IMM, 4'h2, 1'b0, 1'b1);
    chk("mov_nz", 0, zero_result);
    $display("test flags done");
  endtask
  task automatic t_simd;
    send(`OP_MOVSD_RR, 4'h2, 1'b0, 1'b1);
    chk("low_only", 1, write_low_only);
    chk("dep_upper", 1, dep_upper);
    e = {latency, exec_port};
    send(`OP_MOVAPD_RR, 4'h2, 1'b0, 1'b1);
    chk("full", 0, write_low_only | dep_upper);
    chk("port", 1, exec_port != e[1:0]);
    chk("slower", 1, latency > e[5:2]);
    send(`OP_MOVSD_LD, 4'h2, 1'b1, 1'b1);
    chk("zero_fill", 1, zero_fill_upper & dep_break);
    $display("test simd done");
  endtask
  task automatic t_addr;
    @(posedge clk);
    in_reloc <= 32'h100;
    in_imm <= 32'h20;
    in_base <= 32'h1000;
    in_index <= 32'h3;
    in_scale <= 2'h2;
    seg_base_ds <= 32'h10000;
    seg_base_ss <= 32'h20000;
    in_base_reg <= 4'h5;
    e = 32'h112c;
    send(`OP_LOAD, 4'h2, 1'b1, 1'b1);
    chk("lin_flat", e, lin_addr);
    chk("seg_flat", `SEG_DS, seg_used);
    @(posedge clk);
    flat_model <= 1'b0;
    in_base_reg <= 4'h1;
    send(`OP_LOAD, 4'h2, 1'b1, 1'b1);
    chk("lin_ds", e + 32'h10000, lin_addr);
    @(posedge clk);
    in_base_reg <= 4'h5;
    send(`OP_MOVUPD_LD, 4'h2, 1'b1, 1'b0);
    chk("seg", `SEG_SS, seg_used);
    chk("lin_ss", e + 32'h20000, lin_addr);
    chk("hi", e + 32'h20008, lin_addr_hi);
    chk("split", 1, split_load & merge_halves);
    chk("uops", `UOPS_UNALIGNED, uop_count);
    $display("test addr done");
  endtask
  task automatic t_memop;
    send(`OP_ADD_TO_MEM, 4'h2, 1'b1, 1'b1);
    u = uop_count;
    send(`OP_ADD_FROM_MEM, 4'h2, 1'b1, 1'b1);
    chk("one_fewer", u + 3'h1, uop_count);
    $display("test memop done");
  endtask
  task automatic t_hold;
    int n;
    @(posedge clk);
    lag <= 4'h4;
    send(`OP_STORE, 4'h2, 1'b1, 1'b1);
    chk("pending", 1, store_pending);
    @(posedge clk);
    in_op <= `OP_LOAD;
    in_valid <= 1'b1;
    @(posedge clk);
    #1;
    chk("held", 0, out_valid | in_ready);
    n = 0;
    while (store_addr_done !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    in_valid <= 1'b0;
    #1;
    chk("load_out", 1, out_valid);
    chk("load_op", `OP_LOAD, out_op);
    chk("load_dst", 4'h1, out_dst);
    $display("test hold done");
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    @(posedge clk);
    #1;
    chk("reset", 3'h4, {in_ready, out_valid, store_pending});
    @(posedge clk);
    rstn <= 1'b1;
    t_clear;
    t_flags;
    t_simd;
    t_addr;
    t_memop;
    t_hold;
    end_sim;
  end
endmodule // dependency_tracking_rename_tb
